/* core/sucb_wide_event_counter_bank.sv */
// Bank of signed 32-bit wide event counters with an AXI4-Lite register slave
// Summary of operation
// R1 - Each counter holds a signed 32-bit present value and 32-bit setting value.
// R2 - Counting carries on past the setting value instead of stopping there.
// R3 - Contact turns on reaching setting counting up, off reaching it counting down.
// R4 - A clear forces present value to zero and the contact off.
// R5 - Up/down counters each have a direction bit in one bank; high means down.
// R6 - Counting up from the largest positive value wraps to the most negative.
// R7 - Counting down from the most negative value wraps to the largest positive.
// R8 - Power loss clears non-latched counters; latched ones keep value and contact.
// R9 - Setting value comes from a constant or from two 16-bit data registers.
// R10 - Each rising count input edge changes the present value by exactly one.
// R11 - The contact takes its new state only after the count has completed.
// R12 - Lower data register gives the low 16 bits, the next one the high.
// R13 - Up-only counters ignore direction and always count up.
// R14 - Count inputs are sampled and edges found against the previous sample.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sucb_params.svh"
module sucb_wide_event_counter_bank import sucb_pkg::*; #(
  parameter int N_UPDN = 64,
  parameter int N_UP = 136
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Count inputs and power loss level
  input wire logic [N_UPDN+N_UP-1:0] count_in_i,
  input wire logic power_loss_i,
  // Contacts
  output logic [N_UPDN+N_UP-1:0] contact_o,
  // AXI4-Lite write
  input wire logic [15:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [15:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  localparam int N = N_UPDN + N_UP;
  localparam int N_DIRW = (N_UPDN + 31) / 32;
  localparam int UPI = N_UPDN;

  // Counter state
  sucb_word_t present_value_ff [N], set_const_ff [N], set_val [N]; // R1
  sucb_half_t dlo_ff [N], dhi_ff [N];
  logic [N_UPDN-1:0] first_direction_select_bit_ff;
  logic [N-1:0] src_ff, latch_ff, clr_ff, smp_ff, prev_ff, evt_ff, evt_dn_ff;
  logic [N-1:0] contact_ff, cnt_edge, cnt_dn;
  // Bus state
  logic aw_hold_ff, w_hold_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  sucb_addr_t awaddr_ff;
  sucb_word_t wdata_ff, rdata_ff, rd_val;
  logic [3:0] wstrb_ff;
  logic do_wr, rd_err;
  sucb_dec_t wdec, rdec;

  // Address decode shared by both channels
  function automatic sucb_dec_t dec(input sucb_addr_t a);
    sucb_addr_t off;
    off = a - `SUCB_CNT_BASE;
    dec = '0;
    if (a[15:2] < 14'(N_DIRW)) begin
      dec.dir = 1'b1;
      dec.idx = a[9:2];
    end else if (a >= `SUCB_CNT_BASE && 32'(off[15:5]) < N && off[4:2] <= `SUCB_SLOT_STAT) begin
      dec.cnt = 1'b1;
      dec.idx = off[12:5];
      dec.slot = off[4:2];
    end
  endfunction : dec
  // Byte-lane merge of a write
  function automatic sucb_word_t merge(input sucb_word_t old, input sucb_word_t nw,
                                       input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction : merge
  assign wdec = dec(awaddr_ff);
  assign rdec = dec(s_axi_araddr_i);
  assign do_wr = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  // Direction source and setting value per counter
  for (genvar g = 0; g < N; g++) begin : g_cnt
    if (g < N_UPDN) begin : g_ud
      assign cnt_dn[g] = first_direction_select_bit_ff[g]; // R5
    end else begin : g_uo
      assign cnt_dn[g] = 1'b0; // R13
    end
    assign set_val[g] = src_ff[g] ? {dhi_ff[g], dlo_ff[g]} : set_const_ff[g]; // R9 R12
  end
  assign cnt_edge = smp_ff & ~prev_ff; // R14
  // Write address and data capture, one write at a time
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      awaddr_ff <= '0;
      wdata_ff <= `SUCB_RST_WORD;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `SUCB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && awready_ff) begin
        aw_hold_ff <= 1'b1;
        awready_ff <= 1'b0;
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_ff) begin
        w_hold_ff <= 1'b1;
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wdec.dir | wdec.cnt) ? `SUCB_RESP_OKAY : `SUCB_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Software-written configuration and clear pulses
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_direction_select_bit_ff <= '0;
      src_ff <= '0;
      latch_ff <= '0;
      clr_ff <= '0;
      for (int i = 0; i < N; i++) begin
        set_const_ff[i] <= `SUCB_RST_WORD;
        dlo_ff[i] <= `SUCB_RST_HALF;
        dhi_ff[i] <= `SUCB_RST_HALF;
      end
    end else begin
      clr_ff <= '0;
      for (int i = 0; i < N_UPDN; i++) begin
        if (do_wr && wdec.dir && 32'(wdec.idx) == i / 32 && wstrb_ff[(i % 32) / 8]) begin
          first_direction_select_bit_ff[i] <= wdata_ff[i % 32]; // R5
        end
      end
      for (int i = 0; i < N; i++) begin
        if (do_wr && wdec.cnt && 32'(wdec.idx) == i) begin
          case (wdec.slot)
            `SUCB_SLOT_SETC: set_const_ff[i] <= merge(set_const_ff[i], wdata_ff, wstrb_ff);
            `SUCB_SLOT_DLO: dlo_ff[i] <= 16'(merge({16'h0, dlo_ff[i]}, wdata_ff, wstrb_ff));
            `SUCB_SLOT_DHI: dhi_ff[i] <= 16'(merge({16'h0, dhi_ff[i]}, wdata_ff, wstrb_ff));
            `SUCB_SLOT_CTRL: begin
              if (wstrb_ff[0]) begin
                src_ff[i] <= wdata_ff[`SUCB_CTRL_SRC];
                latch_ff[i] <= wdata_ff[`SUCB_CTRL_LATCH];
                clr_ff[i] <= wdata_ff[`SUCB_CTRL_CLR]; // R4
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Input sampling for edge detection
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      smp_ff <= '0;
      prev_ff <= '0;
    end else begin
      smp_ff <= count_in_i; // R14
      prev_ff <= smp_ff; // R14
    end
  end

  // Present value: clear wins, then power loss, then one step per edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      evt_ff <= '0;
      evt_dn_ff <= '0;
      for (int i = 0; i < N; i++) begin
        present_value_ff[i] <= `SUCB_RST_WORD;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        evt_ff[i] <= cnt_edge[i] & ~clr_ff[i] & ~power_loss_i;
        evt_dn_ff[i] <= cnt_dn[i];
        if (clr_ff[i] || (power_loss_i && !latch_ff[i])) begin
          present_value_ff[i] <= `SUCB_RST_WORD; // R4 R8
        end else if (cnt_edge[i] && !power_loss_i) begin
          // Plain 32-bit add wraps at both limits
          present_value_ff[i] <= cnt_dn[i] ? present_value_ff[i] - 32'h1
                                           : present_value_ff[i] + 32'h1; // R2 R6 R7 R10
        end
      end
    end
  end

  // Contact follows one cycle after the count that reached the setting
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      contact_ff <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (clr_ff[i] || (power_loss_i && !latch_ff[i])) begin
          contact_ff[i] <= 1'b0; // R4 R8
        end else if (evt_ff[i] && !power_loss_i && present_value_ff[i] == set_val[i]) begin
          contact_ff[i] <= ~evt_dn_ff[i]; // R3 R11
        end
      end
    end
  end
  assign contact_o = contact_ff;

  // Read data mux
  always_comb begin
    rd_val = '0;
    rd_err = ~(rdec.dir | rdec.cnt);
    if (rdec.dir) begin
      for (int i = 0; i < N_UPDN; i++) begin
        if (32'(rdec.idx) == i / 32) begin
          rd_val[i % 32] = first_direction_select_bit_ff[i];
        end
      end
    end
    for (int i = 0; i < N; i++) begin
      if (rdec.cnt && 32'(rdec.idx) == i) begin
        case (rdec.slot)
          `SUCB_SLOT_PV: rd_val = present_value_ff[i];
          `SUCB_SLOT_SETC: rd_val = set_const_ff[i];
          `SUCB_SLOT_DLO: rd_val = {16'h0, dlo_ff[i]};
          `SUCB_SLOT_DHI: rd_val = {16'h0, dhi_ff[i]};
          `SUCB_SLOT_CTRL: begin
            rd_val[`SUCB_CTRL_SRC] = src_ff[i];
            rd_val[`SUCB_CTRL_LATCH] = latch_ff[i];
          end
          `SUCB_SLOT_STAT: rd_val[`SUCB_STAT_CONTACT] = contact_ff[i];
          default: rd_val = '0;
        endcase
      end
    end
  end

  // Read channel, one read at a time
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= `SUCB_RST_WORD;
      rresp_ff <= `SUCB_RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_err ? `SUCB_RESP_SLVERR : `SUCB_RESP_OKAY;
    end else if (rvalid_ff && s_axi_rready_i) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  // Checks on counter 0 and on the first up-only counter
  a_wrap_up: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R6
    cnt_edge[0] && !cnt_dn[0] && !clr_ff[0] && !power_loss_i
    && present_value_ff[0] == `SUCB_VAL_MAX |=> present_value_ff[0] == `SUCB_VAL_MIN)
    else $error("up wrap failed");
  a_wrap_down: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
    cnt_edge[0] && cnt_dn[0] && !clr_ff[0] && !power_loss_i
    && present_value_ff[0] == `SUCB_VAL_MIN |=> present_value_ff[0] == `SUCB_VAL_MAX)
    else $error("down wrap failed");
  a_step_one: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R10
    cnt_edge[0] && !clr_ff[0] && !power_loss_i |=> present_value_ff[0] ==
    ($past(cnt_dn[0]) ? $past(present_value_ff[0]) - 32'h1 : $past(present_value_ff[0]) + 32'h1))
    else $error("count step not one");
  a_past_setting: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R2
    cnt_edge[0] && !clr_ff[0] && !power_loss_i && present_value_ff[0] == set_val[0]
    |=> present_value_ff[0] != $past(present_value_ff[0]))
    else $error("counter stopped at setting");
  a_contact_on: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3 R11
    (cnt_edge[0] && !cnt_dn[0] && !clr_ff[0] && !power_loss_i
    && present_value_ff[0] + 32'h1 == set_val[0])
    ##1 (!clr_ff[0] && !power_loss_i && $stable(set_val[0])) |=> contact_ff[0])
    else $error("contact not on after up count");
  a_contact_off: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
    (cnt_edge[0] && cnt_dn[0] && !clr_ff[0] && !power_loss_i
    && present_value_ff[0] - 32'h1 == set_val[0])
    ##1 (!clr_ff[0] && !power_loss_i && $stable(set_val[0])) |=> !contact_ff[0])
    else $error("contact not off after down count");
  a_clear_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
    clr_ff[0] |=> present_value_ff[0] == 32'h0 && !contact_ff[0])
    else $error("clear did not zero counter");
  a_power_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R8
    power_loss_i && latch_ff[0] && !clr_ff[0] |=> $stable(present_value_ff[0])
    && $stable(contact_ff[0]))
    else $error("latched counter changed on power loss");
  a_power_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R8
    power_loss_i && !latch_ff[0] |=> present_value_ff[0] == 32'h0 && !contact_ff[0])
    else $error("volatile counter kept value");
  a_up_only: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R13
    cnt_edge[UPI] && !clr_ff[UPI] && !power_loss_i
    |=> present_value_ff[UPI] == $past(present_value_ff[UPI]) + 32'h1)
    else $error("up-only counter did not count up");
  a_edge_seen: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R14
    $rose(count_in_i[0]) |=> cnt_edge[0] ##1 !cnt_edge[0])
    else $error("count edge not detected once");
  a_set_pair: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9 R12
    src_ff[0] && $stable(src_ff[0]) |-> set_val[0][15:0] == dlo_ff[0]
    && set_val[0][31:16] == dhi_ff[0])
    else $error("setting pair misordered");
endmodule : sucb_wide_event_counter_bank

/* core/sucb_params.svh */
// Register offsets, field positions and reset values of the counter bank
`ifndef SUCB_PARAMS_SVH
`define SUCB_PARAMS_SVH
`define SUCB_DIR_BASE 16'h0000
`define SUCB_CNT_BASE 16'h1000
`define SUCB_SLOT_PV 3'h0
`define SUCB_SLOT_SETC 3'h1
`define SUCB_SLOT_DLO 3'h2
`define SUCB_SLOT_DHI 3'h3
`define SUCB_SLOT_CTRL 3'h4
`define SUCB_SLOT_STAT 3'h5
`define SUCB_CTRL_SRC 1
`define SUCB_CTRL_LATCH 2
`define SUCB_CTRL_CLR 3
`define SUCB_STAT_CONTACT 0
`define SUCB_RST_WORD 32'h0000_0000
`define SUCB_RST_HALF 16'h0000
`define SUCB_VAL_MAX 32'h7fff_ffff
`define SUCB_VAL_MIN 32'h8000_0000
`define SUCB_RESP_OKAY 2'h0
`define SUCB_RESP_SLVERR 2'h2
`endif

/* core/sucb_pkg.sv */
// Types shared by the counter bank
package sucb_pkg;
  typedef logic [31:0] sucb_word_t;
  typedef logic [15:0] sucb_half_t;
  typedef logic [15:0] sucb_addr_t;
  typedef struct packed {
    logic dir;
    logic cnt;
    logic [7:0] idx;
    logic [2:0] slot;
  } sucb_dec_t;
endpackage : sucb_pkg

/* tb/sucb_wide_event_counter_bank_tb.sv */
// Self-checking testbench for the wide event counter bank
`timescale 1ns/1ps
`include "sucb_params.svh"
module sucb_wide_event_counter_bank_tb import sucb_pkg::*;;
  localparam int N = 200;
  typedef struct {
    int idx; logic dn; logic src; sucb_word_t setc; sucb_half_t lo; sucb_half_t hi;
    int n; sucb_word_t pv; logic con;
  } sucb_row_t;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [N-1:0] count_in = '0;
  logic power_loss = 1'b0;
  logic [N-1:0] contact;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fails = 0;
  int comparisons = 0;
  sucb_word_t d;
  logic [1:0] r;
  sucb_row_t rows [6];
  // Clock at 50 MHz
  always #10 clk_i = ~clk_i;
  sucb_wide_event_counter_bank #(.N_UPDN(64), .N_UP(136)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .count_in_i(count_in), .power_loss_i(power_loss),
    .contact_o(contact), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready)
  );
  // Verdict and end of run
  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [15:0] ca(input int i, input int s);
    return `SUCB_CNT_BASE + 16'(32 * i) + 16'(4 * s);
  endfunction : ca
  // Bus write: offer address and data together, release each when taken
  task automatic wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] rs);
    int t;
    t = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (t < 50) begin
      @(posedge clk_i);
      t++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (t >= 50) begin
      fails++;
      $display("ERROR %0t write timeout", $time);
      close_out();
    end
  endtask : wr
  // Bus read
  task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
    int t;
    t = 0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (t < 50) begin
      @(posedge clk_i);
      t++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (t >= 50) begin
      fails++;
      $display("ERROR %0t read timeout", $time);
      close_out();
    end
  endtask : rd
  // Count events: input held high two cycles so one edge is seen per event
  task automatic pulse(input logic [N-1:0] m, input int n);
    repeat (n) begin
      @(posedge clk_i);
      count_in <= m;
      repeat (2) @(posedge clk_i);
      count_in <= '0;
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask : pulse
  // Read present value and status, compare with contact pin
  task automatic pv_con(input int i, input sucb_word_t pv, input logic con);
    rd(ca(i, `SUCB_SLOT_PV), d, r);
    chk(d, pv);
    rd(ca(i, `SUCB_SLOT_STAT), d, r);
    chk(d, {31'h0, con});
    chk({31'h0, contact[i]}, {31'h0, con});
  endtask : pv_con
  initial begin
    rows[0] = '{0, 1'b0, 1'b0, 32'h0000_0003, 16'h0000, 16'h0000, 3, 32'h0000_0003, 1'b1};
    rows[1] = '{1, 1'b0, 1'b0, 32'h0000_0002, 16'h0000, 16'h0000, 5, 32'h0000_0005, 1'b1};
    rows[2] = '{63, 1'b1, 1'b0, 32'h0000_0000, 16'h0000, 16'h0000, 3, 32'hffff_fffd, 1'b0};
    rows[3] = '{64, 1'b1, 1'b0, 32'h0000_0002, 16'h0000, 16'h0000, 2, 32'h0000_0002, 1'b1};
    rows[4] = '{5, 1'b0, 1'b1, 32'h0000_0000, 16'h0003, 16'h0000, 3, 32'h0000_0003, 1'b1};
    rows[5] = '{6, 1'b0, 1'b1, 32'h0000_0003, 16'h0000, 16'h0001, 3, 32'h0000_0003, 1'b0};
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // Reset state
    chk(contact[31:0], 32'h0);
    chk({27'h0, awready, wready, arready, bvalid, rvalid}, 32'h0000_001c);
    rd(ca(0, `SUCB_SLOT_PV), d, r);
    chk(d, `SUCB_RST_WORD);
    rd(`SUCB_DIR_BASE, d, r);
    chk(d, `SUCB_RST_WORD);
    $display("test reset done");
    // Table of ordinary counting cases
    foreach (rows[k]) begin
      if (rows[k].idx < 64) wr(16'(4 * (rows[k].idx / 32)),
        32'(rows[k].dn) << (rows[k].idx % 32), r);
      wr(ca(rows[k].idx, `SUCB_SLOT_CTRL), {28'h0, 1'b1, 1'b0, rows[k].src, 1'b0}, r);
      wr(ca(rows[k].idx, `SUCB_SLOT_SETC), rows[k].setc, r);
      wr(ca(rows[k].idx, `SUCB_SLOT_DLO), {16'h0, rows[k].lo}, r);
      wr(ca(rows[k].idx, `SUCB_SLOT_DHI), {16'h0, rows[k].hi}, r);
      pulse(N'(1) << rows[k].idx, rows[k].n);
      pv_con(rows[k].idx, rows[k].pv, rows[k].con);
    end
    $display("test table done");
    // Clear while contact on
    wr(ca(1, `SUCB_SLOT_CTRL), 32'h0000_0008, r);
    pv_con(1, 32'h0, 1'b0);
    // Contact turns off reaching setting while counting down
    wr(`SUCB_DIR_BASE, 32'h0, r);
    wr(ca(0, `SUCB_SLOT_CTRL), 32'h0000_0008, r);
    wr(ca(0, `SUCB_SLOT_SETC), 32'h0000_0001, r);
    pulse(N'(1), 2);
    pv_con(0, 32'h2, 1'b1);
    wr(`SUCB_DIR_BASE, 32'h0000_0001, r);
    pulse(N'(1), 1);
    pv_con(0, 32'h1, 1'b0);
    $display("test clear and down done");
    // Power loss: latched counter 10 keeps, plain counter 11 clears
    wr(ca(10, `SUCB_SLOT_CTRL), 32'h0000_000c, r);
    wr(ca(11, `SUCB_SLOT_CTRL), 32'h0000_0008, r);
    wr(ca(10, `SUCB_SLOT_SETC), 32'h0000_0002, r);
    wr(ca(11, `SUCB_SLOT_SETC), 32'h0000_0002, r);
    pulse((N'(1) << 10) | (N'(1) << 11), 2);
    @(posedge clk_i);
    power_loss <= 1'b1;
    pulse((N'(1) << 10) | (N'(1) << 11), 1);
    power_loss <= 1'b0;
    pv_con(10, 32'h2, 1'b1);
    pv_con(11, 32'h0, 1'b0);
    pulse((N'(1) << 10) | (N'(1) << 11), 1);
    pv_con(10, 32'h3, 1'b1);
    pv_con(11, 32'h1, 1'b0);
    $display("test power loss done");
    // Bus corner cases
    wr(ca(10, `SUCB_SLOT_PV), 32'h0000_0055, r);
    chk({30'h0, r}, {30'h0, `SUCB_RESP_OKAY});
    pv_con(10, 32'h3, 1'b1);
    rd(ca(0, 6), d, r);
    chk({30'h0, r}, {30'h0, `SUCB_RESP_SLVERR});
    chk(d, 32'h0);
    wr(ca(0, 7), 32'h1, r);
    chk({30'h0, r}, {30'h0, `SUCB_RESP_SLVERR});
    wr(`SUCB_DIR_BASE + 16'h0004, 32'ha5a5_0000, r);
    rd(`SUCB_DIR_BASE + 16'h0004, d, r);
    chk(d, 32'ha5a5_0000);
    $display("test bus corners done");
    // Reset in mid-run clears even a latched counter
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    pv_con(10, 32'h0, 1'b0);
    rd(ca(10, `SUCB_SLOT_CTRL), d, r);
    chk(d, 32'h0);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : sucb_wide_event_counter_bank_tb
